/* core/sbpu_top.sv */
// Boot serial service: program-and-verify and endless upload
`timescale 1ns/1ns
`include "sbpu_consts.svh"

// What this block does
// - Upload streams bytes endlessly until reset
// - Defaults loaded before programming starts
// - First default byte lands at D000
// - Send FF ready byte on entry
// - Program byte at pointer, hold programming time
// - Read back, echo verify, wait again
// - Wait loop endless; reset ends programming
// - Count, start, time are user settable
// - Mode pins sampled only during reset
// - Open drain set, transmit only pulls low
// - Other port D pins stay inputs
// - Verify data leaves on transmit pin
// - Default baud 7812, receiver and transmitter on
module sbpu_top (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        serial_receive_pin,
  output logic             serial_transmit_pin_o,
  output logic             serial_transmit_pin_oe,
  output logic [5:0]       portDOe,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             bootMode
);
  sbpu_pkg::sbpu_state_t state_reg;
  logic [15:0] start_reg;
  logic [15:0] count_reg;
  logic [15:0] ptime_reg;
  logic [15:0] baud_reg;
  logic        openDrain_reg;
  logic [15:0] pointer_reg;
  logic [15:0] done_reg;
  logic [23:0] burnCnt_reg;
  logic [7:0]  held_reg;
  logic        heldValid_reg;
  logic        modeA_reg;
  logic        modeB_reg;
  logic        uploadPrimed_reg;
  logic        cmdProg;
  logic        cmdUpload;
  logic        txStart;
  logic [7:0]  txByte;
  logic        txBusy;
  logic        txLow;
  logic        rxValid;
  logic [7:0]  rxByte;
  logic        memWrite;
  logic [7:0]  memRead;
  logic        wbHit;
  logic        wbWrite;

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    laneMerge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // --------------------------------------------------------------
  // Mode pin capture
  // --------------------------------------------------------------
  // Latched while reset is held, frozen afterwards
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      modeA_reg <= mode_select_a;
      modeB_reg <= mode_select_b;
    end
  end
  assign bootMode = !modeA_reg && !modeB_reg;

  // --------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------
  assign wbHit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbHit && wb_we_i;

  // Single-wait-state acknowledge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbHit;
    end
  end

  // Commands are one-cycle strobes from control writes
  assign cmdProg   = wbWrite && wb_adr_i == `SBPU_ADDR_CTRL && wb_sel_i[0]
                     && wb_dat_i[`SBPU_CTRL_PROG];
  assign cmdUpload = wbWrite && wb_adr_i == `SBPU_ADDR_CTRL && wb_sel_i[0]
                     && wb_dat_i[`SBPU_CTRL_UPLOAD];

  // Parameter registers; defaults loaded at reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      start_reg     <= `SBPU_DEF_START;
      count_reg     <= `SBPU_DEF_COUNT;
      ptime_reg     <= `SBPU_DEF_PTIME;
      baud_reg      <= `SBPU_DEF_BAUD;
      openDrain_reg <= 1'b1;
    end else if (wbWrite) begin
      unique case (wb_adr_i)
        `SBPU_ADDR_START: start_reg <= laneMerge(start_reg, wb_dat_i, wb_sel_i);
        `SBPU_ADDR_COUNT: count_reg <= laneMerge(count_reg, wb_dat_i, wb_sel_i);
        `SBPU_ADDR_PTIME: ptime_reg <= laneMerge(ptime_reg, wb_dat_i, wb_sel_i);
        `SBPU_ADDR_BAUD:  baud_reg  <= laneMerge(baud_reg, wb_dat_i, wb_sel_i);
        `SBPU_ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            openDrain_reg <= wb_dat_i[`SBPU_CTRL_OD];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux registered; unmapped reads zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbHit) begin
      unique case (wb_adr_i)
        `SBPU_ADDR_CTRL:    wb_dat_o <= {29'h0, openDrain_reg, 2'h0};
        `SBPU_ADDR_START:   wb_dat_o <= {16'h0, start_reg};
        `SBPU_ADDR_COUNT:   wb_dat_o <= {16'h0, count_reg};
        `SBPU_ADDR_PTIME:   wb_dat_o <= {16'h0, ptime_reg};
        `SBPU_ADDR_BAUD:    wb_dat_o <= {16'h0, baud_reg};
        `SBPU_ADDR_STATUS:  wb_dat_o <= {16'h0, done_reg};
        `SBPU_ADDR_POINTER: wb_dat_o <= {13'h0, state_reg, pointer_reg};
        `SBPU_ADDR_OTP:     wb_dat_o <= {24'h0, memRead};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Received byte holder: host runs one byte ahead
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      heldValid_reg <= 1'b0;
      held_reg      <= 8'h00;
    end else if (rxValid) begin
      heldValid_reg <= 1'b1;
      held_reg      <= rxByte;
    end else if (state_reg == sbpu_pkg::SBPU_WAIT && heldValid_reg) begin
      heldValid_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg   <= sbpu_pkg::SBPU_IDLE;
      pointer_reg <= 16'h0000;
      done_reg    <= 16'h0000;
      burnCnt_reg <= 24'h000000;
    end else begin
      unique case (state_reg)
        sbpu_pkg::SBPU_IDLE: begin
          if (cmdProg && bootMode) begin
            state_reg   <= sbpu_pkg::SBPU_READY;
            pointer_reg <= start_reg;
            done_reg    <= 16'h0000;
          end else if (cmdUpload && bootMode) begin
            state_reg   <= sbpu_pkg::SBPU_UPLOAD;
            pointer_reg <= start_reg;
          end
        end
        sbpu_pkg::SBPU_READY: begin
          if (!txBusy) begin
            state_reg <= sbpu_pkg::SBPU_WAIT;
          end
        end
        sbpu_pkg::SBPU_WAIT: begin
          // Loop never exits without data; only reset ends it
          if (heldValid_reg && done_reg != count_reg) begin
            state_reg   <= sbpu_pkg::SBPU_BURN;
            burnCnt_reg <= 24'(ptime_reg) * 24'(`SBPU_PTIME_UNIT);
          end
        end
        sbpu_pkg::SBPU_BURN: begin
          if (burnCnt_reg <= 24'h000001) begin
            state_reg <= sbpu_pkg::SBPU_VERIFY;
          end else begin
            burnCnt_reg <= burnCnt_reg - 24'h000001;
          end
        end
        sbpu_pkg::SBPU_VERIFY: begin
          state_reg <= sbpu_pkg::SBPU_ECHO;
        end
        sbpu_pkg::SBPU_ECHO: begin
          if (!txBusy) begin
            state_reg   <= sbpu_pkg::SBPU_WAIT;
            pointer_reg <= pointer_reg + 16'h0001;
            done_reg    <= done_reg + 16'h0001;
          end
        end
        sbpu_pkg::SBPU_UPLOAD: begin
          if (!txBusy && uploadPrimed_reg) begin
            pointer_reg <= pointer_reg + 16'h0001;
          end
        end
        default: state_reg <= sbpu_pkg::SBPU_IDLE;
      endcase
    end
  end

  // Transmit requests: ready byte, verify echo, upload stream
  always_comb begin
    txStart = 1'b0;
    txByte  = memRead;
    if (state_reg == sbpu_pkg::SBPU_READY && !txBusy) begin
      txStart = 1'b1;
      txByte  = `SBPU_READY_BYTE;
    end else if ((state_reg == sbpu_pkg::SBPU_ECHO ||
                  (state_reg == sbpu_pkg::SBPU_UPLOAD && uploadPrimed_reg)) && !txBusy) begin
      txStart = 1'b1;
    end
  end

  // Upload read data settles one cycle after the pointer loads
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      uploadPrimed_reg <= 1'b0;
    end else begin
      uploadPrimed_reg <= state_reg == sbpu_pkg::SBPU_UPLOAD;
    end
  end

  // Program strobe on the last wait cycle, as burn is entered
  assign memWrite = state_reg == sbpu_pkg::SBPU_WAIT && heldValid_reg
                    && done_reg != count_reg;

  // --------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------
  // Open drain: drive only the low level
  assign serial_transmit_pin_o  = openDrain_reg ? 1'b0 : !txLow;
  assign serial_transmit_pin_oe = openDrain_reg ? txLow : 1'b1;
  assign portDOe = 6'h00;

  // Registered read port; upload waits one cycle for it
  sbpu_mem u_mem (
    .clock     (clock),
    .writeEn   (memWrite),
    .addr      (pointer_reg[`SBPU_MEM_AW-1:0]),
    .writeData (held_reg),
    .readData  (memRead)
  );

  sbpu_uart u_uart (
    .clock     (clock),
    .reset_n   (reset_n),
    .bitCycles (baud_reg),
    .rxPin     (serial_receive_pin),
    .txLow     (txLow),
    .txStart   (txStart),
    .txByte    (txByte),
    .txBusy    (txBusy),
    .rxValid   (rxValid),
    .rxByte    (rxByte)
  );

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_ready_ff;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == sbpu_pkg::SBPU_READY && txStart) |-> txByte == `SBPU_READY_BYTE;
  endproperty
  a_ready_ff: assert property (p_ready_ff) else $error("ready byte not FF");

  property p_od_high;
    @(posedge clock) disable iff (!reset_n)
      openDrain_reg |-> !(serial_transmit_pin_oe && serial_transmit_pin_o);
  endproperty
  a_od_high: assert property (p_od_high) else $error("open drain drove high");

  property p_portd_in;
    @(posedge clock) disable iff (!reset_n) portDOe == 6'h00;
  endproperty
  a_portd_in: assert property (p_portd_in) else $error("port D pin driven");

  property p_mode_hold;
    @(posedge clock) disable iff (!reset_n) reset_n |=> $stable(bootMode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

  sequence s_burn_done;
    state_reg == sbpu_pkg::SBPU_BURN ##1 state_reg == sbpu_pkg::SBPU_VERIFY;
  endsequence
  property p_verify_echo;
    @(posedge clock) disable iff (!reset_n)
      s_burn_done |=> state_reg == sbpu_pkg::SBPU_ECHO;
  endproperty
  a_verify_echo: assert property (p_verify_echo) else $error("no echo after verify");

  property p_ptr_inc;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == sbpu_pkg::SBPU_ECHO && !txBusy) |=> pointer_reg == $past(pointer_reg) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not stepped");

  property p_upload_stays;
    @(posedge clock) disable iff (!reset_n)
      state_reg == sbpu_pkg::SBPU_UPLOAD |=> state_reg == sbpu_pkg::SBPU_UPLOAD;
  endproperty
  a_upload_stays: assert property (p_upload_stays) else $error("upload left loop");

  property p_burn_write;
    @(posedge clock) disable iff (!reset_n)
      memWrite |=> state_reg == sbpu_pkg::SBPU_BURN;
  endproperty
  a_burn_write: assert property (p_burn_write) else $error("write without burn");

  property p_wait_holds;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == sbpu_pkg::SBPU_WAIT && !heldValid_reg)
        |=> state_reg == sbpu_pkg::SBPU_WAIT;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait loop left");

  property p_boot_only;
    @(posedge clock) disable iff (!reset_n)
      (state_reg == sbpu_pkg::SBPU_IDLE && !bootMode) |=> state_reg == sbpu_pkg::SBPU_IDLE;
  endproperty
  a_boot_only: assert property (p_boot_only) else $error("started outside boot");

  sequence s_upload_cmd;
    state_reg == sbpu_pkg::SBPU_IDLE && cmdUpload && bootMode;
  endsequence
  property p_upload_first;
    @(posedge clock) disable iff (!reset_n)
      s_upload_cmd |=> (pointer_reg == $past(start_reg) && !txStart) ##1 txStart;
  endproperty
  a_upload_first: assert property (p_upload_first) else $error("upload start wrong");
endmodule

/* pkg/sbpu_consts.svh */
// Constants for the serial boot programming and upload block
`ifndef SBPU_CONSTS_SVH
`define SBPU_CONSTS_SVH

// Wishbone register offsets (byte addresses)
`define SBPU_ADDR_CTRL     8'h00
`define SBPU_ADDR_START    8'h04
`define SBPU_ADDR_COUNT    8'h08
`define SBPU_ADDR_PTIME    8'h0C
`define SBPU_ADDR_BAUD     8'h10
`define SBPU_ADDR_STATUS   8'h14
`define SBPU_ADDR_POINTER  8'h18
`define SBPU_ADDR_OTP      8'h1C

// Control register fields
`define SBPU_CTRL_PROG     0
`define SBPU_CTRL_UPLOAD   1
`define SBPU_CTRL_OD       2

// Defaults
`define SBPU_DEF_START     16'hD000
`define SBPU_DEF_COUNT     16'h3000
`define SBPU_DEF_PTIME     16'h0010
`define SBPU_READY_BYTE    8'hFF
`define SBPU_OTP_BLANK     8'hFF

// Bit time: 7812 baud reckoned from the 250 MHz bus clock
`define SBPU_BUS_HZ        250000000
`define SBPU_BAUD_HZ       7812
`define SBPU_DEF_BAUD      16'(`SBPU_BUS_HZ / `SBPU_BAUD_HZ)
`define SBPU_PTIME_UNIT    16'h0100

// Frame layout and array size
`define SBPU_FRAME_BITS    4'hA
`define SBPU_MEM_AW        12
`define SBPU_MEM_DEPTH     4096
`endif

/* pkg/sbpu_pkg.sv */
// Types for the serial boot programming and upload block
package sbpu_pkg;
  // Sequencer states, Gray along the programming path
  typedef enum logic [2:0] {
    SBPU_IDLE   = 3'b000,
    SBPU_READY  = 3'b001,
    SBPU_WAIT   = 3'b011,
    SBPU_BURN   = 3'b010,
    SBPU_VERIFY = 3'b110,
    SBPU_ECHO   = 3'b111,
    SBPU_UPLOAD = 3'b101
  } sbpu_state_t;
endpackage

/* core/sbpu_mem.sv */
// One-time programmable array model with registered read data
`timescale 1ns/1ns
`include "sbpu_consts.svh"
module sbpu_mem (
  input  wire logic                    clock,
  input  wire logic                    writeEn,
  input  wire logic [`SBPU_MEM_AW-1:0] addr,
  input  wire logic [7:0]              writeData,
  output logic      [7:0]              readData
);
  logic [7:0] cells [`SBPU_MEM_DEPTH];

  // Blank cells read erased value
  initial begin
    for (int i = 0; i < `SBPU_MEM_DEPTH; i++) begin
      cells[i] = `SBPU_OTP_BLANK;
    end
  end

  // Programming only clears bits, as in one-time memory
  always_ff @(posedge clock) begin
    if (writeEn) begin
      cells[addr] <= cells[addr] & writeData;
    end
    readData <= cells[addr];
  end
endmodule

/* core/sbpu_uart.sv */
// Ten-bit frame serial transmitter and receiver
`timescale 1ns/1ns
`include "sbpu_consts.svh"
module sbpu_uart (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [15:0] bitCycles,
  input  wire logic        rxPin,
  output logic             txLow,
  input  wire logic        txStart,
  input  wire logic [7:0]  txByte,
  output logic             txBusy,
  output logic             rxValid,
  output logic [7:0]       rxByte
);
  logic [15:0] txCnt_reg;
  logic [3:0]  txBit_reg;
  logic [9:0]  txShift_reg;
  logic [15:0] rxCnt_reg;
  logic [3:0]  rxBit_reg;
  logic [8:0]  rxShift_reg;
  logic        rxActive_reg;

  // --------------------------------------------------------------
  // Transmitter: start, eight data LSB first, stop
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txBit_reg   <= 4'h0;
      txCnt_reg   <= 16'h0000;
      txShift_reg <= 10'h3FF;
    end else if (txBit_reg == 4'h0) begin
      if (txStart) begin
        txShift_reg <= {1'b1, txByte, 1'b0};
        txBit_reg   <= `SBPU_FRAME_BITS;
        txCnt_reg   <= bitCycles;
      end
    end else if (txCnt_reg <= 16'h0001) begin
      txShift_reg <= {1'b1, txShift_reg[9:1]};
      txBit_reg   <= txBit_reg - 4'h1;
      txCnt_reg   <= bitCycles;
    end else begin
      txCnt_reg <= txCnt_reg - 16'h0001;
    end
  end

  assign txBusy = (txBit_reg != 4'h0);
  assign txLow  = txBusy && !txShift_reg[0];

  // --------------------------------------------------------------
  // Receiver: mid-bit sampling
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rxActive_reg <= 1'b0;
      rxBit_reg    <= 4'h0;
      rxCnt_reg    <= 16'h0000;
      rxShift_reg  <= 9'h000;
      rxValid      <= 1'b0;
      rxByte       <= 8'h00;
    end else begin
      rxValid <= 1'b0;
      if (!rxActive_reg) begin
        if (!rxPin) begin
          rxActive_reg <= 1'b1;
          rxBit_reg    <= 4'h0;
          rxCnt_reg    <= {1'b0, bitCycles[15:1]};
        end
      end else if (rxCnt_reg <= 16'h0001) begin
        rxCnt_reg <= bitCycles;
        if (rxBit_reg == 4'h0 && rxPin) begin
          rxActive_reg <= 1'b0; // False start
        end else if (rxBit_reg == `SBPU_FRAME_BITS - 4'h1) begin
          rxActive_reg <= 1'b0;
          rxValid      <= rxPin; // Framing error drops byte
          rxByte       <= rxShift_reg[8:1];
        end else begin
          rxShift_reg <= {rxPin, rxShift_reg[8:1]};
          rxBit_reg   <= rxBit_reg + 4'h1;
        end
      end else begin
        rxCnt_reg <= rxCnt_reg - 16'h0001;
      end
    end
  end
endmodule

/* testbench/sbpu_host_model.sv */
// Host side serial model: sends data bytes and collects returned frames
`timescale 1ns/1ns
module sbpu_host_model #(
  parameter int BitCycles = 16
) (
  input  wire logic clock,
  input  wire logic txLine,
  output logic      rxLine
);
  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  logic [7:0] rxQueue[$];
  logic [7:0] shiftReg;
  int         framingErrors;

  // Line idles high before the first frame
  initial begin
    rxLine = 1'b1;
    framingErrors = 0;
  end

  // Frame collector, samples each bit in its middle
  always begin
    @(posedge clock);
    if (txLine === 1'b0) begin
      repeat (BitCycles / 2) @(posedge clock);
      for (int b = 0; b < 8; b++) begin
        repeat (BitCycles) @(posedge clock);
        shiftReg[b] = txLine;
      end
      repeat (BitCycles) @(posedge clock);
      if (txLine !== 1'b1) begin
        framingErrors++;
      end
      rxQueue.push_back(shiftReg);
    end
  end

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  // One frame after an optional stall, line left high afterwards
  task automatic send_byte(input logic [7:0] value, input int gap);
    logic [9:0] frame;
    frame = {1'b1, value, 1'b0};
    repeat (gap) @(posedge clock);
    for (int b = 0; b < 10; b++) begin
      rxLine <= frame[b];
      repeat (BitCycles) @(posedge clock);
    end
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the boot serial programming and upload block
`timescale 1ns/1ns
`include "sbpu_consts.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock;
  logic        reset_n;
  logic        modeSelectA;
  logic        modeSelectB;
  logic        rxLine;
  logic        txOut;
  logic        txOe;
  logic        txLine;
  logic [5:0]  portDOe;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        bootMode;
  int          mismatches;
  int          checked;
  logic [31:0] rd;

  // Pull-up on the open-drain transmit line
  assign txLine = (txOe === 1'b1) ? txOut : 1'b1;

  sbpu_top sbpu_top_inst (
    .clock                 (clock),
    .reset_n               (reset_n),
    .mode_select_a         (modeSelectA),
    .mode_select_b         (modeSelectB),
    .serial_receive_pin    (rxLine),
    .serial_transmit_pin_o (txOut),
    .serial_transmit_pin_oe(txOe),
    .portDOe               (portDOe),
    .wb_cyc_i              (wbCyc),
    .wb_stb_i              (wbStb),
    .wb_we_i               (wbWe),
    .wb_adr_i              (wbAdr),
    .wb_sel_i              (4'hF),
    .wb_dat_i              (wbDatI),
    .wb_dat_o              (wbDatO),
    .wb_ack_o              (wbAck),
    .bootMode              (bootMode)
  );

  sbpu_host_model #(.BitCycles(16)) host_inst (
    .clock (clock),
    .txLine(txLine),
    .rxLine(rxLine)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check_value(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdata);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rdata = wbDatO;
    if (n >= 50) check_value(32'h0, 32'h1, "bus timeout");
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clock);
  endtask

  // Waits bounded for one returned frame
  task automatic expect_tx(input logic [7:0] exp);
    int n;
    logic [7:0] got;
    n = 0;
    got = 8'hXX;
    while (host_inst.rxQueue.size() == 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (host_inst.rxQueue.size() > 0) got = host_inst.rxQueue.pop_front();
    check_value({24'h000000, got}, {24'h000000, exp}, "frame");
  endtask

  // Reset with given mode pins, pins flipped after release
  task automatic do_reset(input logic a, input logic b);
    reset_n <= 1'b0;
    modeSelectA <= a;
    modeSelectB <= b;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    modeSelectA <= ~a;
    modeSelectB <= ~b;
    host_inst.rxQueue.delete();
    repeat (2) @(posedge clock);
    check_value({31'h0, bootMode}, {31'h0, ~(a | b)}, "boot mode");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_values();
    logic [7:0]  adrs[6] = '{`SBPU_ADDR_CTRL, `SBPU_ADDR_START, `SBPU_ADDR_COUNT,
                             `SBPU_ADDR_PTIME, `SBPU_ADDR_BAUD, 8'h40};
    logic [31:0] exps[6] = '{32'h4, {16'h0, `SBPU_DEF_START}, {16'h0, `SBPU_DEF_COUNT},
                             {16'h0, `SBPU_DEF_PTIME}, {16'h0, `SBPU_DEF_BAUD}, 32'h0};
    for (int i = 0; i < 6; i++) begin
      wb_cycle(1'b0, adrs[i], 32'h0, rd);
      check_value(rd, exps[i], "reset value");
    end
    check_value({26'h0, portDOe}, 32'h0, "port d enables");
  endtask

  task automatic test_program();
    logic [7:0] data[3] = '{8'hA5, 8'h3C, 8'h0F};
    wb_cycle(1'b1, `SBPU_ADDR_BAUD, 32'h10, rd);
    wb_cycle(1'b1, `SBPU_ADDR_PTIME, 32'h1, rd);
    wb_cycle(1'b1, `SBPU_ADDR_CTRL, 32'h5, rd);
    expect_tx(`SBPU_READY_BYTE);
    host_inst.send_byte(data[0], 0);
    host_inst.send_byte(data[1], 0);
    for (int i = 0; i < 3; i++) begin
      expect_tx(data[i] & `SBPU_OTP_BLANK);
      if (i == 0) host_inst.send_byte(data[2], 40);
    end
    wb_cycle(1'b0, `SBPU_ADDR_STATUS, 32'h0, rd);
    check_value(rd, 32'h3, "bytes done");
    wb_cycle(1'b0, `SBPU_ADDR_POINTER, 32'h0, rd);
    check_value(rd, {13'h0, sbpu_pkg::SBPU_WAIT, 16'hD003}, "pointer");
  endtask

  task automatic test_upload();
    wb_cycle(1'b1, `SBPU_ADDR_BAUD, 32'h10, rd);
    wb_cycle(1'b1, `SBPU_ADDR_START, 32'hD001, rd);
    wb_cycle(1'b1, `SBPU_ADDR_CTRL, 32'h6, rd);
    expect_tx(8'h3C);
    expect_tx(8'h0F);
    expect_tx(`SBPU_OTP_BLANK);
    expect_tx(`SBPU_OTP_BLANK);
  endtask

  task automatic test_not_boot();
    wb_cycle(1'b1, `SBPU_ADDR_BAUD, 32'h10, rd);
    wb_cycle(1'b1, `SBPU_ADDR_CTRL, 32'h5, rd);
    repeat (400) @(posedge clock);
    check_value(host_inst.rxQueue.size(), 32'h0, "frames outside boot");
  endtask

  // ----------------------------------------
  // Processes
  // ----------------------------------------
  // Clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Transmit pin may only pull low, other port D pins stay inputs
  always @(posedge clock) begin
    if (reset_n === 1'b1 && txOe === 1'b1) check_value({31'h0, txOut}, 32'h0, "od");
    if (reset_n === 1'b1 && portDOe !== 6'h00) check_value({26'h0, portDOe}, 32'h0, "oe");
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    reset_n = 1'b0;
    modeSelectA = 1'b0;
    modeSelectB = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    @(posedge clock);
    do_reset(1'b0, 1'b0);
    test_reset_values();
    test_program();
    do_reset(1'b0, 1'b0);
    test_upload();
    do_reset(1'b1, 1'b0);
    test_not_boot();
    check_value(host_inst.framingErrors, 32'h0, "stop bits");
    give_verdict();
  end
endmodule
